// ==== verif/pio8_board.sv ====
// Board model on the six pins.
// Assumes pin_oe_n low where the device drives.
`timescale 1ns/10ps
module pio8_board (
  input  wire [5:0] pin_out,
  input  wire [5:0] pin_oe_n,
  input  wire [5:0] drv,
  output wire [5:0] pin_in
);
  // Driven bits follow the device, the rest the board
  assign pin_in = (pin_out & ~pin_oe_n) | (drv & pin_oe_n);
endmodule // pio8_board

// ==== verif/pio8_checker.sv ====
// Checker for the six-pin port block.
// Assumes bind to pio8_port, one clock mclk.
`timescale 1ns/10ps
`include "pio8_defs.vh"
module pio8_checker (
  input wire        mclk,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire [5:0]  pin_out,
  input wire [5:0]  pin_oe_n
);
  // ************
  // Properties
  // ************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire rd = psel && !penable && !pwrite;
  wire wr = psel && penable && pwrite && pready;
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_dir; rd && paddr == `PIO8_OFF_DIR |=> prdata == 0; endproperty
  a_dir: assert property (p_dir) else $error("direction readable");
  property p_od; rd && paddr == `PIO8_OFF_ODATA |=> prdata[31:6] == 0; endproperty
  a_od: assert property (p_od) else $error("data high bits set");
  property p_pin; rd && paddr == `PIO8_OFF_PIN |=> prdata[31:6] == 0; endproperty
  a_pin: assert property (p_pin) else $error("pin high bits set");
  property p_rst; $rose(nrst) |-> pin_oe_n == 6'h3f && pin_out == 0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset pins");
  property p_oe; $changed(pin_oe_n[1:0]) |-> $past(wr && paddr == `PIO8_OFF_DIR, 2); endproperty
  a_oe: assert property (p_oe) else $error("enable moved alone");
  property p_out; $changed(pin_out[1:0]) |-> $past(wr && paddr == `PIO8_OFF_ODATA, 2); endproperty
  a_out: assert property (p_out) else $error("output moved alone");
endmodule // pio8_checker
bind pio8_port pio8_checker pio8_checker_i (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ==== verif/tb_pio8_port.sv ====
// Testbench for the six-pin port block.
// Assumes pio8_port, pio8_board and the bound checker.
`timescale 1ns/10ps
module tb_pio8_port;
  reg          mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [7:0]   paddr = 0;
  reg  [31:0]  pwdata = 0, rnd = 62;
  reg          scm = 0, a3 = 0, a2 = 0, e3 = 0, e2 = 0;
  reg  [5:0]   drv = 6'h3f;
  wire [31:0]  prdata;
  wire         pready, pslverr, irq;
  wire [5:0]   pin_in, pin_out, pin_oe_n;
  wire [3:0]   irq_input_n;
  logic [31:0] q[$];
  integer      miscompares = 0, check_count = 0, n;
  always #12.5 mclk = ~mclk;
  pio8_port pio8_port_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_chip_mode(scm), .ext_dma_ack_ch3(a3), .ext_dma_ack_ch2(a2),
    .ext_dma_end_ch3(e3), .ext_dma_end_ch2(e2), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq_input_n(irq_input_n), .irq(irq));
  pio8_board pio8_board_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv(drv),
    .pin_in(pin_in));
  // ************
  // Tasks
  // ************
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task test_done;
    begin
      $display("checks %0d bad %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      if (!w) q.push_back(d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      for (i = 0; i < 20 && !pready; i = i + 1) @(negedge mclk);
      if (i == 20) begin
        miscompares = miscompares + 1;
        test_done;
      end
      @(posedge mclk);
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Read results against the oldest expectation
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) chk(prdata, q.pop_front());
    if (psel && penable && pready) chk(pslverr, paddr > 8'h18);
  end
  // ************
  // Sequence
  // ************
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1;
    chk(pin_oe_n, 6'h3f);
    apb(0, 8'h04, 0);
    apb(0, 8'h00, 0);
    $display("reset test done");
    for (n = 0; n < 3; n = n + 1) begin
      rnd = xs(rnd);
      apb(1, 8'h00, 32'hff);
      apb(1, 8'h04, rnd);
      apb(0, 8'h04, rnd & 32'h3f);
      apb(0, 8'h08, rnd & 32'h3f);
      chk(pin_out, rnd[5:0]);
      chk(pin_oe_n, 0);
    end
    drv <= rnd[13:8];
    apb(1, 8'h00, 32'h15);
    apb(1, 8'h08, 32'hff);
    apb(0, 8'h08, (rnd & 32'h15) | (rnd[13:8] & 6'h2a));
    $display("gpio test done");
    drv <= 6'h3f;
    {a3, a2, e3, e2} <= 4'b1010;
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 32'h14);
    apb(1, 8'h0c, 32'h0f);
    @(posedge mclk);
    @(negedge mclk);
    chk({pin_oe_n[5:2], pin_out[5:2]}, 8'h0a);
    @(posedge mclk);
    scm <= 1;
    repeat (2) @(posedge mclk);
    chk(pin_oe_n[5:2], 4'hf);
    apb(1, 8'h0c, 32'h1f);
    @(posedge mclk);
    @(negedge mclk);
    chk(pin_oe_n[5:2], 0);
    $display("alternate test done");
    apb(1, 8'h0c, 0);
    apb(1, 8'h10, 32'hf);
    apb(1, 8'h18, 32'h1);
    drv <= 6'h3b;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(irq_input_n, 4'he);
    chk(irq, 1);
    apb(0, 8'h14, 1);
    apb(1, 8'h18, 0);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(irq, 0);
    apb(1, 8'h14, 1);
    apb(0, 8'h14, 0);
    apb(0, 8'h1c, 0);
    $display("interrupt test done");
    test_done;
  end
endmodule // tb_pio8_port

// ==== verilog/pio8_defs.vh ====
// Constants for the six-pin port block: register offsets, reset values, field positions.
// Assumes an APB slave with 32-bit words and byte addresses.
`ifndef PIO8_DEFS_VH
`define PIO8_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PIO8_OFF_DIR      8'h00
`define PIO8_OFF_ODATA    8'h04
`define PIO8_OFF_PIN      8'h08
`define PIO8_OFF_ALT      8'h0C
`define PIO8_OFF_ISEL     8'h10
`define PIO8_OFF_IRQ_STAT 8'h14
`define PIO8_OFF_IRQ_MASK 8'h18

// ****************************************
// Reset values
// ****************************************
`define PIO8_DIR_RST      6'h00
`define PIO8_ODATA_RST    6'h00
`define PIO8_ALT_RST      5'h00
`define PIO8_ISEL_RST     4'h0
`define PIO8_IRQ_RST      4'h0

// ****************************************
// Alternate function control fields
// ****************************************
`define PIO8_ALT_AMS3     0
`define PIO8_ALT_AMS2     1
`define PIO8_ALT_TEE3     2
`define PIO8_ALT_TEE2     3
`define PIO8_ALT_EXTERNAL_EXPANSION_ENABLE     4

// Undefined reads return this fill
`define PIO8_UNDEF_FILL   32'h0000_0000

`endif

// ==== verilog/pio8_irq.v ====
// Sticky interrupt status with mask and write-one-to-clear.
// Assumes events are one-cycle pulses on mclk.
`timescale 1ns/10ps
`include "pio8_defs.vh"

module pio8_irq #(
  parameter N = 4
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire [N-1:0] event_in,
  input  wire [N-1:0] clear_in,
  input  wire [N-1:0] mask_in,
  output reg  [N-1:0] status_reg,
  output reg          irq_out
);

  wire [N-1:0] status_next;

  // Set wins over clear
  assign status_next = (status_reg & ~clear_in) | event_in;

  // ****************************************
  // Status and interrupt line
  // ****************************************
  always @(posedge mclk) begin
    if (!nrst) begin
      status_reg <= {N{1'b0}};
      irq_out    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_out    <= |(status_next & mask_in);
    end
  end

endmodule // pio8_irq

// ==== verilog/pio8_port.v ====
// Six-pin general purpose port with alternate DMA and interrupt pin functions.
// Assumes an APB master on mclk; pins are asynchronous and synchronised here.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pio8_defs.vh"

module pio8_port #(
  parameter NPIN = 6
) (
  input  wire            mclk,
  input  wire            nrst,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire            single_chip_mode,
  input  wire            ext_dma_ack_ch3,
  input  wire            ext_dma_ack_ch2,
  input  wire            ext_dma_end_ch3,
  input  wire            ext_dma_end_ch2,
  input  wire [NPIN-1:0] pin_in,
  output reg  [NPIN-1:0] pin_out,
  output reg  [NPIN-1:0] pin_oe_n,
  output reg  [3:0]      irq_input_n,
  output reg             irq
);

  // ****************************************
  // Declarations
  // ****************************************
  reg  [NPIN-1:0] port_direction_reg;
  reg  [NPIN-1:0] port_output_data_reg;
  reg  [4:0]      alt_ctrl_reg;
  reg  [3:0]      interrupt_pin_select_register_reg;
  reg  [3:0]      irq_mask_reg;
  reg  [3:0]      pin_prev_reg;
  reg  [31:0]     rdata_next;
  reg             err_next;
  reg  [NPIN-1:0] pin_out_next;
  reg  [NPIN-1:0] pin_oe_n_next;
  wire [NPIN-1:0] pin_sync;
  wire [NPIN-1:0] port_pin_state;
  wire [3:0]      irq_status;
  wire            irq_line;
  wire            wr_en;
  wire            rd_en;
  wire            alt_allowed;
  wire            ack3_en;
  wire            ack2_en;
  wire            end3_en;
  wire            end2_en;
  wire [3:0]      irq_level_n;
  wire [3:0]      irq_event;
  wire [3:0]      irq_clear;

  // ****************************************
  // Submodules
  // ****************************************
  pio8_sync #(
    .WIDTH (NPIN)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  pio8_irq #(
    .N (4)
  ) u_irq (
    .mclk       (mclk),
    .nrst       (nrst),
    .event_in   (irq_event),
    .clear_in   (irq_clear),
    .mask_in    (irq_mask_reg),
    .status_reg (irq_status),
    .irq_out    (irq_line)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  // ****************************************
  // Pin function selection
  // ****************************************
  assign alt_allowed = ~single_chip_mode | alt_ctrl_reg[`PIO8_ALT_EXTERNAL_EXPANSION_ENABLE];
  assign ack3_en = alt_allowed & alt_ctrl_reg[`PIO8_ALT_AMS3];
  assign ack2_en = alt_allowed & alt_ctrl_reg[`PIO8_ALT_AMS2];
  assign end3_en = alt_allowed & alt_ctrl_reg[`PIO8_ALT_TEE3];
  assign end2_en = alt_allowed & alt_ctrl_reg[`PIO8_ALT_TEE2];

  // Read-back mixes stored data and live pin levels per bit
  assign port_pin_state = (port_direction_reg & port_output_data_reg) |
                          (~port_direction_reg & pin_sync);

  // Interrupt routing and falling-edge events on selected pins
  assign irq_level_n = ~interrupt_pin_select_register_reg | pin_sync[5:2];
  assign irq_event   = interrupt_pin_select_register_reg & pin_prev_reg & ~pin_sync[5:2];
  assign irq_clear   = (wr_en && paddr == `PIO8_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0;

  always @* begin
    pin_out_next  = port_output_data_reg;
    pin_oe_n_next = ~port_direction_reg;
    if (ack3_en) begin
      pin_out_next[5]  = ext_dma_ack_ch3;
      pin_oe_n_next[5] = 1'b0;
    end
    if (ack2_en) begin
      pin_out_next[4]  = ext_dma_ack_ch2;
      pin_oe_n_next[4] = 1'b0;
    end
    if (end3_en) begin
      pin_out_next[3]  = ext_dma_end_ch3;
      pin_oe_n_next[3] = 1'b0;
    end
    if (end2_en) begin
      pin_out_next[2]  = ext_dma_end_ch2;
      pin_oe_n_next[2] = 1'b0;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (paddr == `PIO8_OFF_DIR) begin
      rdata_next = `PIO8_UNDEF_FILL;
    end else if (paddr == `PIO8_OFF_ODATA) begin
      rdata_next = {26'h000_0000, port_output_data_reg};
    end else if (paddr == `PIO8_OFF_PIN) begin
      rdata_next = {26'h000_0000, port_pin_state};
    end else if (paddr == `PIO8_OFF_ALT) begin
      rdata_next = {27'h000_0000, alt_ctrl_reg};
    end else if (paddr == `PIO8_OFF_ISEL) begin
      rdata_next = {28'h000_0000, interrupt_pin_select_register_reg};
    end else if (paddr == `PIO8_OFF_IRQ_STAT) begin
      rdata_next = {28'h000_0000, irq_status};
    end else if (paddr == `PIO8_OFF_IRQ_MASK) begin
      rdata_next = {28'h000_0000, irq_mask_reg};
    end else begin
      err_next = 1'b1;
    end
  end

  // ****************************************
  // Registers and APB answer
  // ****************************************
  always @(posedge mclk) begin
    if (!nrst) begin
      port_direction_reg                <= `PIO8_DIR_RST;
      port_output_data_reg              <= `PIO8_ODATA_RST;
      alt_ctrl_reg                      <= `PIO8_ALT_RST;
      interrupt_pin_select_register_reg <= `PIO8_ISEL_RST;
      irq_mask_reg                      <= `PIO8_IRQ_RST;
      pin_prev_reg                      <= 4'hF;
      prdata                            <= 32'h0000_0000;
      pready                            <= 1'b0;
      pslverr                           <= 1'b0;
      pin_out                           <= {NPIN{1'b0}};
      pin_oe_n                          <= {NPIN{1'b1}};
      irq_input_n                       <= 4'hF;
      irq                               <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync[5:2];
      pin_out      <= pin_out_next;
      pin_oe_n     <= pin_oe_n_next;
      irq_input_n  <= irq_level_n;
      irq          <= irq_line;
      pready       <= psel & ~penable;
      pslverr      <= psel & ~penable & err_next;
      if (psel && !penable && rd_en) begin
        prdata <= rdata_next;
      end
      if (wr_en && pready) begin
        if (paddr == `PIO8_OFF_DIR) begin
          port_direction_reg <= pwdata[NPIN-1:0];
        end else if (paddr == `PIO8_OFF_ODATA) begin
          port_output_data_reg <= pwdata[NPIN-1:0];
        end else if (paddr == `PIO8_OFF_ALT) begin
          alt_ctrl_reg <= pwdata[4:0];
        end else if (paddr == `PIO8_OFF_ISEL) begin
          interrupt_pin_select_register_reg <= pwdata[3:0];
        end else if (paddr == `PIO8_OFF_IRQ_MASK) begin
          irq_mask_reg <= pwdata[3:0];
        end
      end
    end
  end

endmodule // pio8_port

// ==== verilog/pio8_sync.v ====
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes the inputs are asynchronous to mclk.
`timescale 1ns/10ps
`include "pio8_defs.vh"

module pio8_sync #(
  parameter WIDTH = 6
) (
  input  wire             mclk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // ****************************************
  // Two stages
  // ****************************************
  always @(posedge mclk) begin
    if (!nrst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pio8_sync
